// ===== verilog/dmc_pkg.sv
package dmc_pkg;
	// word index of each register; byte address is index * 4
	localparam logic [3:0] IDX_STATUS    = 4'h0;
	localparam logic [3:0] IDX_MODE      = 4'h1;
	localparam logic [3:0] IDX_MAIN      = 4'h2;
	localparam logic [3:0] IDX_AUX       = 4'h3;
	localparam logic [3:0] IDX_FILT      = 4'h4;
	localparam logic [3:0] IDX_IRQ_STAT  = 4'h5;
	localparam logic [3:0] IDX_IRQ_EN    = 4'h6;
	localparam logic [3:0] IDX_IRQ_CLR   = 4'h7;
	localparam logic [3:0] IDX_MAIN_DATA = 4'h8;
	localparam logic [3:0] IDX_AUX_DATA  = 4'h9;
	localparam logic [3:0] IDX_ZCOEF     = 4'ha;
	localparam logic [3:0] IDX_FCOEF     = 4'hb;
	localparam logic [3:0] IDX_ACOEF     = 4'hc;
	// mode select codes
	localparam logic [2:0] MODE_PWRDN  = 3'h0;
	localparam logic [2:0] MODE_IDLE   = 3'h1;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_CONT   = 3'h3;
	localparam int MODE_CAL_BIT  = 2;
	localparam int MODE_FS_BIT   = 0;
	localparam int MODE_CHANNEL_CONFIG_BIT    = 4;
	// main control fields
	localparam int MAIN_EN_BIT   = 7;
	localparam int MAIN_WL_BIT   = 6;
	localparam int MAIN_CH_HI    = 5;
	localparam int MAIN_CH_LO    = 4;
	localparam int MAIN_UB_BIT   = 3;
	localparam int MAIN_RN_HI    = 2;
	// aux control fields
	localparam int AUX_EN_BIT    = 7;
	localparam int AUX_SEL_HI    = 6;
	localparam int AUX_SEL_LO    = 4;
	localparam logic [2:0] AUX_SEL_TEMP = 3'h7;
	// reset values and filter word limits
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] MAIN_RST  = 8'h07;
	localparam logic [7:0] AUX_RST   = 8'h00;
	localparam logic [7:0] FILT_RST  = 8'h45;
	localparam logic [7:0] SF_MAX    = 8'hff;
	localparam logic [7:0] SF_MIN    = 8'h01;
	// status and interrupt bits
	localparam int ST_MAIN_RDY = 0;
	localparam int ST_AUX_RDY  = 1;
	localparam int ST_CAL_BUSY = 2;
	localparam int IRQ_W       = 3;
	localparam int IRQ_MAIN    = 0;
	localparam int IRQ_AUX     = 1;
	localparam int IRQ_CAL     = 2;
	// counts of main output periods
	localparam logic [1:0] AUX_ALIGN_OUTPUTS = 2'h2;
	localparam logic [1:0] CAL_OUTPUTS       = 2'h2;
	typedef enum logic [0:0] {DMC_CAL_IDLE, DMC_CAL_RUN} dmc_cal_e;
endpackage

// ===== verilog/dmc_top.sv
`timescale 1ns/100ps
module dmc_top
	import dmc_pkg::*;
#(
	parameter int CYC_PER_SF = 16
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// modulator samples
	input  wire logic [23:0] main_sample_in,
	input  wire logic [15:0] aux_sample_in,
	// front end control
	output logic             main_pwr_en,
	output logic             aux_pwr_en,
	output logic             main_filter_rst,
	output logic             aux_filter_rst,
	output logic [1:0]       input_pair_sel,
	output logic             cal_pair_sel,
	output logic [2:0]       range_sel,
	// interrupt
	output logic             irq
);
	if (CYC_PER_SF < 1 || CYC_PER_SF > 255) begin : g_chk
		$error("CYC_PER_SF must be 1 to 255");
	end

	logic [3:0]  addr_reg;
	logic        map_ok_reg;
	logic        wr_pend_reg;
	logic        rd_pend_reg;
	logic [7:0]  mode_reg;
	logic [7:0]  main_reg;
	logic [7:0]  aux_reg;
	logic [7:0]  filt_reg;
	logic [2:0]  status_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_en_reg;
	logic [23:0] main_data_reg;
	logic [15:0] aux_data_reg;
	logic [23:0] zcoef_reg [2];
	logic [23:0] fcoef_reg [2];
	logic [15:0] acoef_reg;
	logic [15:0] conv_cnt_reg;
	logic [1:0]  aux_wait_reg;
	logic [1:0]  cal_cnt_reg;
	dmc_cal_e    cal_reg;

	logic        accept;
	logic        wr_mode, wr_main, wr_aux, wr_filt, wr_clr, wr_en;
	logic        rd_main_data, rd_aux_data;
	logic        main_rst_pulse, aux_rst_pulse;
	logic        main_en, aux_en, is_cal, conv_mode, running, tick;
	logic        main_done, aux_done, cal_done, cal_blocked;
	logic [7:0]  sf_eff;
	logic [15:0] period;
	logic [16:0] rnd;
	logic [23:0] main_res;
	logic [31:0] rd_mux;

	// bus front end: writes take no wait, reads take one
	assign accept = hsel & htrans[1] & hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg    <= 4'h0;
			map_ok_reg  <= 1'b0;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			hreadyout   <= 1'b1;
		end else if (accept) begin
			addr_reg    <= haddr[5:2];
			map_ok_reg  <= (haddr[31:6] == 26'h0);
			wr_pend_reg <= hwrite;
			rd_pend_reg <= !hwrite;
			hreadyout   <= hwrite;
		end else begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			hreadyout   <= 1'b1;
		end
	end

	assign wr_en        = wr_pend_reg & map_ok_reg;
	assign wr_mode      = wr_en && addr_reg == IDX_MODE;
	assign wr_main      = wr_en && addr_reg == IDX_MAIN;
	assign wr_aux       = wr_en && addr_reg == IDX_AUX;
	assign wr_filt      = wr_en && addr_reg == IDX_FILT;
	assign wr_clr       = wr_en && addr_reg == IDX_IRQ_CLR;
	assign rd_main_data = rd_pend_reg && map_ok_reg && addr_reg == IDX_MAIN_DATA;
	assign rd_aux_data  = rd_pend_reg && map_ok_reg && addr_reg == IDX_AUX_DATA;

	// converter resets
	assign main_rst_pulse = wr_mode
		| (wr_main & (hwdata[MAIN_EN_BIT] | main_reg[MAIN_EN_BIT]));
	assign aux_rst_pulse  = main_rst_pulse | wr_aux;

	assign main_en   = main_reg[MAIN_EN_BIT];
	assign aux_en    = aux_reg[AUX_EN_BIT];
	assign is_cal    = mode_reg[MODE_CAL_BIT];
	assign conv_mode = mode_reg[2:0] == MODE_SINGLE || mode_reg[2:0] == MODE_CONT;
	assign running   = (conv_mode | is_cal) & (main_en | aux_en);
	assign sf_eff    = (cal_reg == DMC_CAL_RUN) ? SF_MAX :
		((filt_reg < SF_MIN) ? SF_MIN : filt_reg);
	assign period    = 16'(sf_eff) * 16'(CYC_PER_SF);
	assign tick      = running && !main_rst_pulse && conv_cnt_reg == period - 16'h1;

	assign main_done   = tick & conv_mode & main_en;
	assign aux_done    = tick & conv_mode & aux_en & (aux_wait_reg == 2'h0);
	assign cal_blocked = aux_en && aux_reg[AUX_SEL_HI:AUX_SEL_LO] == AUX_SEL_TEMP;
	assign cal_done    = tick && cal_reg == DMC_CAL_RUN && cal_blocked == 1'b0
		&& cal_cnt_reg == CAL_OUTPUTS - 2'h1;

	// rounding to 16 bits saturates at full scale
	assign rnd      = {1'b0, main_sample_in[23:8]} + 17'(main_sample_in[7]);
	assign main_res = main_reg[MAIN_WL_BIT] ?
		{8'h00, (rnd[16] ? 16'hffff : rnd[15:0])} : main_sample_in;

	// conversion timer, restarted by any main reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_cnt_reg <= 16'h0;
		end else if (main_rst_pulse || !running || tick) begin
			conv_cnt_reg <= 16'h0;
		end else begin
			conv_cnt_reg <= conv_cnt_reg + 16'h1;
		end
	end

	// aux alignment to main output ticks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aux_wait_reg <= AUX_ALIGN_OUTPUTS;
		end else if (aux_rst_pulse || !aux_en) begin
			aux_wait_reg <= AUX_ALIGN_OUTPUTS;
		end else if (tick && aux_wait_reg != 2'h0) begin
			aux_wait_reg <= aux_wait_reg - 2'h1;
		end
	end

	// calibration sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_reg     <= DMC_CAL_IDLE;
			cal_cnt_reg <= 2'h0;
		end else if (wr_mode) begin
			cal_reg     <= hwdata[MODE_CAL_BIT] ? DMC_CAL_RUN : DMC_CAL_IDLE;
			cal_cnt_reg <= 2'h0;
		end else begin
			case (cal_reg)
				DMC_CAL_IDLE: cal_cnt_reg <= 2'h0;
				DMC_CAL_RUN: begin
					if (cal_done) begin
						cal_reg <= DMC_CAL_IDLE;
					end else if (main_rst_pulse) begin
						cal_cnt_reg <= 2'h0;
					end else if (tick && cal_cnt_reg != CAL_OUTPUTS - 2'h1) begin
						cal_cnt_reg <= cal_cnt_reg + 2'h1;
					end
				end
				default: cal_reg <= DMC_CAL_IDLE;
			endcase
		end
	end

	// coefficient store, one pair per value of the low bit of the main input pair code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zcoef_reg[0] <= 24'h0;
			zcoef_reg[1] <= 24'h0;
			fcoef_reg[0] <= 24'h0;
			fcoef_reg[1] <= 24'h0;
			acoef_reg    <= 16'h0;
		end else if (cal_done) begin
			if (main_en && mode_reg[MODE_FS_BIT]) begin
				fcoef_reg[main_reg[MAIN_CH_LO]] <= main_sample_in;
			end else if (main_en) begin
				zcoef_reg[main_reg[MAIN_CH_LO]] <= main_sample_in;
			end
			if (aux_en) begin
				acoef_reg <= aux_sample_in;
			end
		end
	end

	// mode register: bus write wins over hardware return to idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= MODE_RST;
		end else if (wr_mode) begin
			mode_reg <= {3'h0, hwdata[MODE_CHANNEL_CONFIG_BIT], 1'b0, hwdata[2:0]};
		end else if (cal_done || ((main_done | aux_done) && mode_reg[2:0] == MODE_SINGLE)) begin
			mode_reg[2:0] <= MODE_IDLE;
		end
	end

	// software control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_reg   <= MAIN_RST;
			aux_reg    <= AUX_RST;
			filt_reg   <= FILT_RST;
			irq_en_reg <= '0;
		end else begin
			if (wr_main) main_reg <= hwdata[7:0];
			if (wr_aux) aux_reg <= hwdata[7:0];
			if (wr_filt) filt_reg <= hwdata[7:0];
			if (wr_en && addr_reg == IDX_IRQ_EN) irq_en_reg <= hwdata[IRQ_W-1:0];
		end
	end

	// results and ready flags; a new result wins over a read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_data_reg <= 24'h0;
			aux_data_reg  <= 16'h0;
			status_reg    <= 3'h0;
		end else begin
			if (main_done) main_data_reg <= main_res;
			if (aux_done) aux_data_reg <= aux_sample_in;
			if (wr_mode && hwdata[MODE_CAL_BIT]) begin
				status_reg[ST_AUX_RDY:ST_MAIN_RDY] <= 2'h0;
			end else begin
				if (main_done) status_reg[ST_MAIN_RDY] <= 1'b1;
				else if (rd_main_data) status_reg[ST_MAIN_RDY] <= 1'b0;
				if (aux_done) status_reg[ST_AUX_RDY] <= 1'b1;
				else if (rd_aux_data) status_reg[ST_AUX_RDY] <= 1'b0;
			end
			status_reg[ST_CAL_BUSY] <= wr_mode ? hwdata[MODE_CAL_BIT] :
				(cal_reg == DMC_CAL_RUN && !cal_done);
		end
	end

	// sticky interrupt status, set beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_reg <= '0;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? hwdata[IRQ_W-1:0] : '0))
				| {cal_done, aux_done, main_done};
			irq          <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// front end controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_pwr_en     <= 1'b0;
			aux_pwr_en      <= 1'b0;
			main_filter_rst <= 1'b1;
			aux_filter_rst  <= 1'b1;
			input_pair_sel  <= 2'h0;
			cal_pair_sel    <= 1'b0;
			range_sel       <= 3'h7;
		end else begin
			main_pwr_en     <= main_en && mode_reg[2:0] != MODE_PWRDN;
			aux_pwr_en      <= aux_en && mode_reg[2:0] != MODE_PWRDN;
			main_filter_rst <= main_rst_pulse || !(main_en && running);
			aux_filter_rst  <= aux_rst_pulse || !(aux_en && running);
			input_pair_sel  <= main_reg[MAIN_CH_HI:MAIN_CH_LO];
			cal_pair_sel    <= main_reg[MAIN_CH_LO];
			range_sel       <= main_reg[MAIN_RN_HI:0];
		end
	end

	// read mux; bit 7 of each byte register is its most significant bit
	always_comb begin
		rd_mux = 32'h0;
		if (map_ok_reg) begin
			case (addr_reg)
				IDX_STATUS:    rd_mux = {29'h0, status_reg};
				IDX_MODE:      rd_mux = {24'h0, mode_reg};
				IDX_MAIN:      rd_mux = {24'h0, main_reg};
				IDX_AUX:       rd_mux = {24'h0, aux_reg};
				IDX_FILT:      rd_mux = {24'h0, filt_reg};
				IDX_IRQ_STAT:  rd_mux = {29'h0, irq_stat_reg};
				IDX_IRQ_EN:    rd_mux = {29'h0, irq_en_reg};
				IDX_MAIN_DATA: rd_mux = {8'h0, main_data_reg};
				IDX_AUX_DATA:  rd_mux = {16'h0, aux_data_reg};
				IDX_ZCOEF:     rd_mux = {8'h0, zcoef_reg[main_reg[MAIN_CH_LO]]};
				IDX_FCOEF:     rd_mux = {8'h0, fcoef_reg[main_reg[MAIN_CH_LO]]};
				IDX_ACOEF:     rd_mux = {16'h0, acoef_reg};
				default:       rd_mux = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hresp  <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (rd_pend_reg) hrdata <= rd_mux;
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_cal_write;
		wr_mode && hwdata[MODE_CAL_BIT];
	endsequence
	sequence s_flags_clear;
		status_reg[ST_AUX_RDY:ST_MAIN_RDY] == 2'h0 && cal_reg == DMC_CAL_RUN;
	endsequence

	a_mode_wr_rst: assert property (wr_mode |=> main_filter_rst && aux_filter_rst
		&& conv_cnt_reg == 16'h0) else $error("mode write did not reset converters");
	a_same_mode_rst: assert property (wr_mode && hwdata[2:0] == mode_reg[2:0]
		|=> aux_wait_reg == AUX_ALIGN_OUTPUTS) else $error("same mode write no reset");
	a_main_en_rst: assert property (wr_main && hwdata[MAIN_EN_BIT]
		|=> conv_cnt_reg == 16'h0 && aux_filter_rst) else $error("main write no reset");
	a_aux_only: assert property (wr_aux && !main_rst_pulse && running && !tick
		|=> conv_cnt_reg == $past(conv_cnt_reg) + 16'h1) else $error("aux write hit main");
	a_aux_align: assert property (aux_rst_pulse |=> !aux_done [*2])
		else $error("aux result before alignment");
	a_cal_start: assert property (s_cal_write |=> s_flags_clear)
		else $error("calibration start did not clear flags");
	a_cal_idle: assert property (cal_done && !wr_mode
		|=> mode_reg[2:0] == MODE_IDLE && cal_reg == DMC_CAL_IDLE) else $error("no idle");
	a_cal_block: assert property (cal_reg == DMC_CAL_RUN && cal_blocked && !wr_mode
		|=> cal_reg == DMC_CAL_RUN && status_reg[ST_CAL_BUSY]) else $error("blocked cal ended");
	a_cal_sf: assert property (cal_reg == DMC_CAL_RUN |-> period == 16'(SF_MAX)
		* 16'(CYC_PER_SF)) else $error("calibration filter word wrong");
	a_sf_restore: assert property ($fell(cal_reg == DMC_CAL_RUN) && filt_reg >= SF_MIN
		|-> sf_eff == filt_reg) else $error("filter word not restored");
	a_main_read: assert property (rd_pend_reg && map_ok_reg && addr_reg == IDX_MAIN
		|=> hreadyout && hrdata == {24'h0, $past(main_reg)}) else $error("main read wrong");
	a_main_off: assert property (!main_en [*2] |-> !main_pwr_en && main_filter_rst)
		else $error("disabled main converter not powered down");
	a_wl16: assert property (main_done && main_reg[MAIN_WL_BIT]
		|=> main_data_reg[23:16] == 8'h0) else $error("16 bit result too wide");
	a_wl24: assert property (main_done && !main_reg[MAIN_WL_BIT]
		|=> main_data_reg == $past(main_sample_in)) else $error("24 bit result wrong");
	a_idle_hold: assert property (mode_reg[2:0] == MODE_IDLE |=> main_filter_rst
		&& aux_filter_rst) else $error("idle did not hold filters");
	a_rst_restart: assert property (main_rst_pulse |=> !main_done || period == 16'h1)
		else $error("result right after converter reset");
endmodule // dmc_top

// ===== bench/dmc_host.sv
`timescale 1ns/100ps
module dmc_host (
	// clock
	input  wire logic        hclk,
	// ahb-lite master
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [31:0]      hwdata
);
	initial begin
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end

	// one single word transfer; address held until hready, then data held until hready
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d; // control byte msb rides in bit 7
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		// released data lines show the inverse, not the last value
		hwdata <= ~d;
	endtask
endmodule // dmc_host

// ===== bench/test_dmc_top.sv
`timescale 1ns/100ps
module test_dmc_top;
	import dmc_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [23:0] main_s;
	logic [15:0] aux_s;
	logic        main_pwr_en;
	logic        aux_pwr_en;
	logic        main_filter_rst;
	logic        aux_filter_rst;
	logic [1:0]  input_pair_sel;
	logic        cal_pair_sel;
	logic [2:0]  range_sel;
	logic        irq;
	int          n_fail;
	int          tests_run;
	int          cyc;
	int          i;

	dmc_top #(.CYC_PER_SF(1)) u_dmc_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.main_sample_in(main_s), .aux_sample_in(aux_s), .main_pwr_en(main_pwr_en),
		.aux_pwr_en(aux_pwr_en), .main_filter_rst(main_filter_rst),
		.aux_filter_rst(aux_filter_rst), .input_pair_sel(input_pair_sel),
		.cal_pair_sel(cal_pair_sel), .range_sel(range_sel), .irq(irq)
	);

	dmc_host u_dmc_host (
		.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata)
	);

	always #12.5 hclk = ~hclk;

	function automatic logic [31:0] ad(input logic [3:0] idx);
		return {26'h0, idx, 2'b00};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		logic [31:0] q;
		u_dmc_host.xfer(ad(idx), 1'b1, d, q);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		u_dmc_host.xfer(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic wait_irq(input int lim);
		int k;
		// let irq follow a clear that has just landed
		repeat (2) @(posedge hclk);
		for (k = 0; k < lim && irq !== 1'b1; k++)
			@(posedge hclk);
	endtask

	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			complete_run;
		end
	end

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		main_s = 24'h0;
		aux_s = 16'h0;
		n_fail = 0;
		tests_run = 0;
		cyc = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(ad(IDX_MAIN), 32'h07);
		rd(ad(IDX_MODE), 32'h0);
		rd(ad(IDX_FILT), 32'h45);
		rd(32'h100, 32'h0);
		chk({main_filter_rst, main_pwr_en, range_sel}, {1'b1, 1'b0, 3'h7});
		wr(IDX_FILT, 32'h8);
		wr(IDX_IRQ_EN, 32'h1);
		wr(IDX_MODE, 32'h3);
		wr(IDX_MAIN, 32'h95);
		rd(ad(IDX_MAIN), 32'h95);
		chk({input_pair_sel, cal_pair_sel, range_sel}, {2'h1, 1'b1, 3'h5});
		chk({main_pwr_en, main_filter_rst, hresp}, 3'h4);
		main_s <= 24'h123456;
		wr(IDX_IRQ_CLR, 32'h7);
		wait_irq(40);
		rd(ad(IDX_MAIN_DATA), 32'h123456);
		wr(IDX_MAIN, 32'hc0);
		main_s <= 24'h654300;
		wr(IDX_IRQ_CLR, 32'h7);
		wait_irq(40);
		rd(ad(IDX_MAIN_DATA), 32'h6543);
		chk({input_pair_sel, cal_pair_sel}, 3'h0);
		// idle, then mask and clear the interrupt
		wr(IDX_MODE, 32'h1);
		repeat (2) @(posedge hclk);
		chk(main_filter_rst, 1'b1);
		wr(IDX_IRQ_EN, 32'h0);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0);
		wr(IDX_IRQ_EN, 32'h1);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b1);
		wr(IDX_IRQ_CLR, 32'h7);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0);
		// repeated mode and main writes keep restarting the main output period, aux writes do not
		wr(IDX_MODE, 32'h3);
		wr(IDX_IRQ_CLR, 32'h7);
		for (i = 0; i < 5; i++)
			wr(IDX_MODE, 32'h3);
		rd(ad(IDX_IRQ_STAT), 32'h0);
		for (i = 0; i < 5; i++)
			wr(IDX_MAIN, 32'h80);
		rd(ad(IDX_IRQ_STAT), 32'h0);
		wr(IDX_IRQ_CLR, 32'h7);
		for (i = 0; i < 5; i++)
			wr(IDX_AUX, 32'h80);
		rd(ad(IDX_IRQ_STAT), 32'h1);
		chk({aux_pwr_en, aux_filter_rst}, 2'h2);
		aux_s <= 16'h5a5a;
		wr(IDX_IRQ_EN, 32'h2);
		wr(IDX_AUX, 32'h80);
		wr(IDX_IRQ_CLR, 32'h7);
		repeat (8) @(posedge hclk);
		chk(irq, 1'b0);
		wait_irq(40);
		chk(irq, 1'b1);
		rd(ad(IDX_AUX_DATA), 32'h5a5a);
		// calibration with both converters enabled
		wr(IDX_IRQ_EN, 32'h4);
		main_s <= 24'h00abcd;
		wr(IDX_MODE, 32'h4);
		rd(ad(IDX_STATUS), 32'h4);
		repeat (300) @(posedge hclk);
		chk(irq, 1'b0);
		wait_irq(1000);
		chk(irq, 1'b1);
		rd(ad(IDX_MODE), 32'h1);
		rd(ad(IDX_ZCOEF), 32'habcd);
		rd(ad(IDX_ACOEF), 32'h5a5a);
		wr(IDX_IRQ_EN, 32'h1);
		wr(IDX_IRQ_CLR, 32'h7);
		wr(IDX_MODE, 32'h3);
		wait_irq(30);
		chk(irq, 1'b1);
		// single conversion falls back to idle
		wr(IDX_MODE, 32'h2);
		wr(IDX_IRQ_CLR, 32'h7);
		wait_irq(30);
		rd(ad(IDX_MODE), 32'h1);
		// full scale calibration fills the full coefficient
		wr(IDX_IRQ_EN, 32'h4);
		wr(IDX_MODE, 32'h5);
		wait_irq(1000);
		rd(ad(IDX_FCOEF), 32'habcd);
		wr(IDX_IRQ_CLR, 32'h7);
		// aux calibration on the temperature sensor never ends
		wr(IDX_MODE, 32'h1);
		wr(IDX_AUX, 32'hf0);
		wr(IDX_IRQ_EN, 32'h4);
		wr(IDX_MODE, 32'h4);
		repeat (1200) @(posedge hclk);
		chk(irq, 1'b0);
		rd(ad(IDX_STATUS), 32'h4);
		complete_run;
	end
endmodule // test_dmc_top
